// ==== logic/dac_serial_consts.svh ====
// Constants for the dual converter serial input block
// What this block does
// - Frame sync low starts a write; each falling serial clock shifts one bit
// - Word is applied on the 16th falling edge while frame sync stays low
// - Frame sync rising before the 16th edge discards the partial word
// - Word carries channel select, mode, power-down and a 12-bit code
// - Two-bit mode chooses load only, update of a single channel, simultaneous update of both, or power-down
// - After reset both outputs hold code zero until a complete write
// - Power-down selectable by the word with three termination options
`ifndef DAC_SERIAL_CONSTS_SVH
`define DAC_SERIAL_CONSTS_SVH

`define WORD_BITS 16
`define CODE_BITS 12
`define BIT_COUNT_W 5
`define FRAME_LAST_BIT 5'h0F

`define PIN_RESET 3'h6

`define REG_CTRL 4'h0
`define REG_CHAN_A 4'h4
`define REG_CHAN_B 4'h8
`define REG_STATUS 4'hC
`define CTRL_LINK_EN 0
`define CTRL_RESET 1'h1
`define CODE_RESET 12'h000
`define CNT_RESET 8'h00

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== logic/dac_serial_pkg.sv ====
// Types for the dual converter serial input block
package dac_serial_pkg;

   typedef enum logic [1:0] {
      MODE_LOAD = 2'h0,
      MODE_UPDATE_ONE = 2'h1,
      MODE_UPDATE_BOTH = 2'h2,
      MODE_POWER_DOWN = 2'h3
   } dac_mode_t;

   typedef struct packed {
      dac_mode_t mode;
      logic [1:0] sel;
      logic [11:0] code;
   } dac_word_t;

   typedef enum logic [2:0] {
      LINK_IDLE = 3'h1,
      LINK_SHIFT = 3'h2,
      LINK_DONE = 3'h4
   } link_state_t;

   typedef struct packed {
      logic [7:0] aborted;
      logic [7:0] applied;
      logic [11:0] spare;
      logic busy;
      logic powerDown;
      logic [1:0] termination;
   } dac_status_t;

endpackage

// ==== logic/dual_dac_serial_input.sv ====
// Serial input logic of a dual 12-bit converter with AXI4-Lite status port
`include "dac_serial_consts.svh"

module dual_dac_serial_input
   import dac_serial_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic linkClk,
   input wire logic frameSync_n,
   input wire logic serialData,
   output logic [11:0] channel_a_output,
   output logic [11:0] channel_b_output,
   output logic powerDown,
   output logic [1:0] pdTermination,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstPipe;
   logic rstN;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) rstPipe <= 2'h0;
      else rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstN = rstPipe[1];

   // ----------------------------------------------------------------
   // Pin sampling, three stages, change taken once stages two and three agree
   // ----------------------------------------------------------------
   logic [2:0] pinS1, pinS2, pinS3, pinF, pinPrev;
   logic [2:0] pinRaw, pinAgree;
   assign pinRaw = {linkClk, frameSync_n, serialData};
   assign pinAgree = ~(pinS2 ^ pinS3);
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         pinS1 <= `PIN_RESET;
         pinS2 <= `PIN_RESET;
         pinS3 <= `PIN_RESET;
         pinF <= `PIN_RESET;
         pinPrev <= `PIN_RESET;
      end else begin
         pinS1 <= pinRaw;
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         pinF <= (pinAgree & pinS3) | (~pinAgree & pinF);
         pinPrev <= pinF;
      end
   end

   logic sclkFall, syncLow, syncFall, syncRise, dinF;
   assign sclkFall = pinPrev[2] & ~pinF[2];
   assign syncLow = ~pinF[1];
   assign syncFall = pinPrev[1] & ~pinF[1];
   assign syncRise = ~pinPrev[1] & pinF[1];
   assign dinF = pinF[0];

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   link_state_t state, next_state;
   logic [`BIT_COUNT_W-1:0] bitCount;
   logic [`WORD_BITS-1:0] shiftReg;
   logic linkEnable;
   logic takeBit, lastBit, abortFrame;
   dac_word_t fullWord;

   assign takeBit = (state == LINK_SHIFT) && syncLow && sclkFall;
   assign lastBit = takeBit && (bitCount == `FRAME_LAST_BIT);
   assign abortFrame = (state == LINK_SHIFT) && !syncLow;
   assign fullWord = dac_word_t'({shiftReg[`WORD_BITS-2:0], dinF});

   always_comb begin
      next_state = state;
      case (state)
         LINK_IDLE: if (syncFall && linkEnable) next_state = LINK_SHIFT;
         LINK_SHIFT: begin
            if (abortFrame) next_state = LINK_IDLE;
            else if (lastBit) next_state = LINK_DONE;
         end
         LINK_DONE: if (!syncLow) next_state = LINK_IDLE;
         default: next_state = LINK_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state <= LINK_IDLE;
         bitCount <= '0;
         shiftReg <= '0;
      end else begin
         state <= next_state;
         if (state == LINK_IDLE) bitCount <= '0;
         else if (takeBit) bitCount <= bitCount + 5'h01;
         if (takeBit) shiftReg <= {shiftReg[`WORD_BITS-2:0], dinF};
      end
   end

   // ----------------------------------------------------------------
   // Word decode and converter registers
   // ----------------------------------------------------------------
   logic [11:0] holdA, holdB;
   logic loadA, loadB, updA, updB, enterPd, leavePd;
   assign loadA = lastBit && fullWord.mode != MODE_POWER_DOWN && !fullWord.sel[1];
   assign loadB = lastBit && fullWord.mode != MODE_POWER_DOWN && fullWord.sel[1];
   assign updA = lastBit && ((fullWord.mode == MODE_UPDATE_ONE && !fullWord.sel[1])
                 || fullWord.mode == MODE_UPDATE_BOTH);
   assign updB = lastBit && ((fullWord.mode == MODE_UPDATE_ONE && fullWord.sel[1])
                 || fullWord.mode == MODE_UPDATE_BOTH);
   assign enterPd = lastBit && fullWord.mode == MODE_POWER_DOWN && fullWord.sel != 2'h0;
   assign leavePd = lastBit && (updA || updB
                    || (fullWord.mode == MODE_POWER_DOWN && fullWord.sel == 2'h0));

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         holdA <= `CODE_RESET;
         holdB <= `CODE_RESET;
         channel_a_output <= `CODE_RESET;
         channel_b_output <= `CODE_RESET;
         powerDown <= 1'b0;
         pdTermination <= 2'h0;
      end else begin
         if (loadA) holdA <= fullWord.code;
         if (loadB) holdB <= fullWord.code;
         if (updA) channel_a_output <= loadA ? fullWord.code : holdA;
         if (updB) channel_b_output <= loadB ? fullWord.code : holdB;
         if (enterPd) begin
            powerDown <= 1'b1;
            pdTermination <= fullWord.sel;
         end else if (leavePd) begin
            powerDown <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame counters
   // ----------------------------------------------------------------
   logic [7:0] appliedCount, abortedCount;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         appliedCount <= `CNT_RESET;
         abortedCount <= `CNT_RESET;
      end else begin
         if (lastBit) appliedCount <= appliedCount + 8'h01;
         if (abortFrame) abortedCount <= abortedCount + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic [3:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic awHeld, wHeld, doWrite, awTake, wTake, arTake;
   logic wrMapped, rdMapped;
   logic [31:0] rdValue;
   dac_status_t statusWord;

   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;
   assign arTake = s_axi_arvalid && s_axi_arready;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign wrMapped = awAddr == `REG_CTRL || awAddr == `REG_CHAN_A
                     || awAddr == `REG_CHAN_B || awAddr == `REG_STATUS;
   assign rdMapped = s_axi_araddr == `REG_CTRL || s_axi_araddr == `REG_CHAN_A
                     || s_axi_araddr == `REG_CHAN_B || s_axi_araddr == `REG_STATUS;
   assign statusWord = '{aborted: abortedCount, applied: appliedCount, spare: 12'h000,
                         busy: state != LINK_IDLE, powerDown: powerDown, termination: pdTermination};
   assign rdValue = (s_axi_araddr == `REG_CTRL) ? {31'h00000000, linkEnable} :
                    (s_axi_araddr == `REG_CHAN_A) ? {4'h0, holdA, 4'h0, channel_a_output} :
                    (s_axi_araddr == `REG_CHAN_B) ? {4'h0, holdB, 4'h0, channel_b_output} :
                    (s_axi_araddr == `REG_STATUS) ? 32'(statusWord) : 32'h00000000;

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 4'h0;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         linkEnable <= `CTRL_RESET;
      end else begin
         if (awTake) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (wTake) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
            if (awAddr == `REG_CTRL && wStrb[0]) linkEnable <= wData[`CTRL_LINK_EN];
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (arTake) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdValue;
         s_axi_rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstN);

   logic everApplied;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) everApplied <= 1'b0;
      else if (lastBit) everApplied <= 1'b1;
   end

   sequence s_lastEdge;
      (state == LINK_SHIFT) && syncLow && sclkFall && bitCount == 5'h0F;
   endsequence

   property p_shift_count;
      takeBit && !lastBit |=> bitCount == $past(bitCount) + 5'h01 && state == LINK_SHIFT;
   endproperty
   a_shift_count: assert property (p_shift_count) else $error("bit not counted on clock fall");

   property p_apply_on_16;
      s_lastEdge ##1 1'b1 |-> state == LINK_DONE && appliedCount == $past(appliedCount) + 8'h01;
   endproperty
   a_apply_on_16: assert property (p_apply_on_16) else $error("word not applied on 16th edge");

   property p_abort_keeps;
      abortFrame |=> state == LINK_IDLE && $stable(channel_a_output) && $stable(channel_b_output)
                     && $stable(powerDown) && $stable(holdA) && $stable(holdB);
   endproperty
   a_abort_keeps: assert property (p_abort_keeps) else $error("aborted frame changed state");

   property p_code_lands;
      lastBit && fullWord.mode == MODE_UPDATE_ONE && !fullWord.sel[1]
      |=> channel_a_output == $past(fullWord.code) && $stable(channel_b_output);
   endproperty
   a_code_lands: assert property (p_code_lands) else $error("channel A code not taken");

   property p_both_together;
      lastBit && fullWord.mode == MODE_UPDATE_BOTH
      |=> channel_a_output == holdA && channel_b_output == holdB;
   endproperty
   a_both_together: assert property (p_both_together) else $error("outputs not updated together");

   property p_zero_until_write;
      !everApplied |-> channel_a_output == 12'h000 && channel_b_output == 12'h000;
   endproperty
   a_zero_until_write: assert property (p_zero_until_write) else $error("output left zero early");

   property p_power_down;
      lastBit && fullWord.mode == MODE_POWER_DOWN && fullWord.sel != 2'h0
      |=> powerDown && pdTermination == $past(fullWord.sel) && $stable(channel_a_output);
   endproperty
   a_power_down: assert property (p_power_down) else $error("power-down not entered");

   property p_msb_first;
      takeBit |=> shiftReg == {$past(shiftReg[14:0]), $past(dinF)};
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

endmodule

// ==== tb/serial_host_model.sv ====
// Behavioural host driving the three-wire serial link
module serial_host_model (
   output logic linkClk,
   output logic frameSync_n,
   output logic serialData
);
   timeunit 1ns;
   timeprecision 100ps;

   // Link clock and frame sync idle high between frames
   initial begin
      linkClk = 1'b1;
      frameSync_n = 1'b1;
      serialData = 1'b0;
   end

   // Sends the top nBits of w; fewer than 16 aborts the frame
   task automatic send_word(input logic [15:0] w, input int nBits);
      frameSync_n <= 1'b0;
      #100;
      for (int i = 0; i < nBits; i++) begin
         serialData <= w[15 - i];
         #100 linkClk <= 1'b0;
         #100 linkClk <= 1'b1;
      end
      #100 frameSync_n <= 1'b1;
      // Released data line no longer shows the last bit
      serialData <= ~serialData;
      #200;
   endtask
endmodule

// ==== tb/tb_dual_dac_serial_input.sv ====
// Self-checking testbench for the dual converter serial input block
module tb_dual_dac_serial_input
   import dac_serial_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic core_clk;
   logic reset_n;
   logic [3:0] awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'h0;
   logic [31:0] wData = 32'h00000000;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic linkClk, frameSync_n, serialData, powerDown;
   logic [11:0] chA, chB;
   logic [1:0] pdTerm, bResp, rResp;
   logic awReady, wReady, bValid, arReady, rValid;
   logic [31:0] rData;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;

   dual_dac_serial_input dut (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .linkClk(linkClk),
      .frameSync_n(frameSync_n),
      .serialData(serialData),
      .channel_a_output(chA),
      .channel_b_output(chB),
      .powerDown(powerDown),
      .pdTermination(pdTerm),
      .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid),
      .s_axi_awready(awReady),
      .s_axi_wdata(wData),
      .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid),
      .s_axi_wready(wReady),
      .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid),
      .s_axi_bready(bReady),
      .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid),
      .s_axi_arready(arReady),
      .s_axi_rdata(rData),
      .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid),
      .s_axi_rready(rReady)
   );

   serial_host_model host (
      .linkClk(linkClk),
      .frameSync_n(frameSync_n),
      .serialData(serialData)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge core_clk);
      awAddr <= a;
      wData <= d;
      wStrb <= s;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
      end while (!bValid);
      chk("bresp", er, bResp);
      bReady <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arValid && arReady) arValid <= 1'b0;
      end while (!rValid);
      chk("rdata", ed, rData & m);
      chk("rresp", er, rResp);
      rReady <= 1'b0;
   endtask

   task automatic send(input logic [15:0] w, input int n);
      host.send_word(w, n);
      repeat (12) @(posedge core_clk);
   endtask

   task automatic outs(input logic [11:0] a, input logic [11:0] b);
      chk("channel_a_output", a, chA);
      chk("channel_b_output", b, chB);
   endtask

   task automatic t_reset;
      outs(12'h000, 12'h000);
      chk("powerDown", 1'b0, powerDown);
      rd(4'h0, 32'h00000001, 32'h00000001, 2'h0);
      rd(4'h6, 32'hFFFFFFFF, 32'h00000000, 2'h2);
   endtask

   task automatic t_single;
      send({MODE_UPDATE_ONE, 2'h0, 12'h123}, 16);
      outs(12'h123, 12'h000);
      send({MODE_UPDATE_ONE, 2'h2, 12'h5A5}, 16);
      outs(12'h123, 12'h5A5);
      rd(4'h4, 32'h0FFF0FFF, 32'h01230123, 2'h0);
   endtask

   task automatic t_both;
      send({MODE_LOAD, 2'h0, 12'h0F0}, 16);
      outs(12'h123, 12'h5A5);
      send({MODE_UPDATE_BOTH, 2'h2, 12'hABC}, 16);
      outs(12'h0F0, 12'hABC);
   endtask

   task automatic t_abort;
      send({MODE_UPDATE_ONE, 2'h0, 12'hFFF}, 15);
      outs(12'h0F0, 12'hABC);
      rd(4'hC, 32'hFFFF000F, 32'h01040000, 2'h0);
      send({MODE_UPDATE_ONE, 2'h0, 12'h321}, 16);
      outs(12'h321, 12'hABC);
   endtask

   task automatic t_power;
      for (int s = 1; s < 4; s++) begin
         send({MODE_POWER_DOWN, s[1:0], 12'h000}, 16);
         chk("powerDown", 1'b1, powerDown);
         chk("pdTermination", s[1:0], pdTerm);
         outs(12'h321, 12'hABC);
      end
      send({MODE_POWER_DOWN, 2'h0, 12'h000}, 16);
      chk("powerDown", 1'b0, powerDown);
   endtask

   task automatic t_enable;
      wr(4'h0, 32'h00000000, 4'hE, 2'h0);
      rd(4'h0, 32'h00000001, 32'h00000001, 2'h0);
      wr(4'h0, 32'h00000000, 4'hF, 2'h0);
      send({MODE_UPDATE_ONE, 2'h2, 12'h777}, 16);
      outs(12'h321, 12'hABC);
      wr(4'h6, 32'h00000001, 4'hF, 2'h2);
      wr(4'h0, 32'h00000001, 4'hF, 2'h0);
      send({MODE_UPDATE_ONE, 2'h2, 12'h777}, 16);
      outs(12'h321, 12'h777);
   endtask

   initial begin
      reset_n = 1'b0;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_single();
      t_both();
      t_abort();
      t_power();
      t_enable();
      final_report();
   end
endmodule
